// File: hdl/swc_consts.svh
`ifndef SWC_CONSTS_SVH
`define SWC_CONSTS_SVH

// register byte offsets
`define SWC_OFF_SYSCTRL2   8'h00
`define SWC_OFF_TBCTRL     8'h04
`define SWC_OFF_IRQCTRL    8'h08
`define SWC_OFF_STATUS     8'h0C
`define SWC_OFF_PC         8'h10

// sys_ctrl_two bit positions
`define SWC_BIT_CPUHALT    2
`define SWC_BIT_TIMING_GEN_HALT     4
`define SWC_BIT_SLOWSEL    5
`define SWC_BIT_LFOSC      6
`define SWC_BIT_HFOSC      7

// timebase_ctrl fields
`define SWC_BIT_TBEN       3
`define SWC_TBSEL_LSB      0
`define SWC_TBSEL_W        3

// irq control fields
`define SWC_BIT_MASTER     0
`define SWC_BIT_TBIE       1

// reset values
`define SWC_RST_SYSCTRL2   8'h80
`define SWC_RST_TBCTRL     8'h00

// program counter advance added while running, held while halted
`define SWC_PC_STEP        16'h0002
// count loaded on leaving slow; fast-clock synchronisation lasts this many cycles plus one before the switch
`define SWC_SYNC_CYC       4'h3

`endif

// File: hdl/swc_pkg.sv
package swc_pkg;
    typedef enum logic [2:0] {
        SWC_FAST     = 3'b000,
        SWC_DUALFAST = 3'b001,
        SWC_SLOW     = 3'b010,
        SWC_SYNC     = 3'b011,
        SWC_HALT     = 3'b100,
        SWC_DEEP     = 3'b101
    } swc_mode_t;
endpackage

// File: hdl/swc_edge_fall.sv
module swc_edge_fall (
    // clock and reset
    input  wire logic clk,
    input  wire logic sys_rst,
    // level in, pulse out
    input  wire logic levelIn,
    output logic      fallPulse
);
    logic prevReg;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            prevReg <= 1'b0;
        end else begin
            prevReg <= levelIn;
        end
    end

    assign fallPulse = prevReg & ~levelIn;
endmodule

// File: hdl/swc_standby_ctrl.sv
`include "swc_consts.svh"

module swc_standby_ctrl #(
    parameter int NUM_SRC = 8,
    parameter int TB_SRC  = 6
) (
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 sys_rst,
    // axi4-lite write address
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [7:0]           s_axi_awaddr,
    // axi4-lite write data
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    // axi4-lite write response
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    output logic [1:0]                s_axi_bresp,
    // axi4-lite read
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    input  wire logic [7:0]           s_axi_araddr,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    // interrupt controller side
    input  wire logic [NUM_SRC-1:0]   irqPending,
    input  wire logic                 watchdogIrq,
    input  wire logic                 cpuPcValid,
    input  wire logic [15:0]          cpuPc,
    output logic                      setTbPending,
    output logic                      serviceStart,
    output logic                      resumeNoService,
    // timebase source clocks, sampled
    input  wire logic [7:0]           tbSrcClocks,
    // clock and oscillator control
    output logic                      cpuClkRun,
    output logic                      wdtClkRun,
    output logic                      periphClkRun,
    output logic                      tbClkRun,
    output logic                      useFastClk,
    output logic                      hfOscOn,
    output logic                      lfOscOn,
    output logic [2:0]                modeOut
);
    // refuse source counts above 16 and a timebase source outside the source range
    if (NUM_SRC < 1 || NUM_SRC > 16 || TB_SRC < 0 || TB_SRC >= NUM_SRC) begin
        $error("swc_standby_ctrl: bad source count");
    end

    typedef struct packed {
        swc_pkg::swc_mode_t mode;
        swc_pkg::swc_mode_t retMode;
        logic [7:0]         sysCtrl2;
        logic [7:0]         tbCtrl;
        logic [1:0]         irqCtrl;
        logic [NUM_SRC-1:0] srcEnable;
        logic [15:0]        heldPc;
        logic [3:0]         syncCnt;
        logic               awDone;
        logic               wDone;
        logic               awReady;
        logic               wReady;
        logic [7:0]         awAddr;
        logic [31:0]        wData;
        logic [3:0]         wStrb;
        logic               bValid;
        logic [1:0]         bResp;
        logic               arReady;
        logic               rValid;
        logic [31:0]        rData;
        logic [1:0]         rResp;
        logic               setTb;
        logic               svc;
        logic               noSvc;
        logic [9:0]         outs;
    } swc_state_t;

    swc_state_t stateReg;
    swc_state_t stateNext;
    logic       tbFall;
    logic       wrFire;
    logic       andTerm;
    logic       wakeReq;

    // selected timebase source falling edge
    swc_edge_fall uFall (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .levelIn   (tbSrcClocks[stateReg.tbCtrl[`SWC_TBSEL_LSB +: `SWC_TBSEL_W]]),
        .fallPulse (tbFall)
    );

    assign andTerm = stateReg.irqCtrl[`SWC_BIT_MASTER] & stateReg.irqCtrl[`SWC_BIT_TBIE]
                   & stateReg.tbCtrl[`SWC_BIT_TBEN];
    assign wakeReq = |(irqPending & stateReg.srcEnable);
    assign wrFire  = stateReg.awDone & stateReg.wDone & ~stateReg.bValid;

    always_comb begin
        stateNext       = stateReg;
        stateNext.setTb = 1'b0;
        stateNext.svc   = 1'b0;
        stateNext.noSvc = 1'b0;

        // write channel capture, either order
        if (s_axi_awvalid && !stateReg.awDone) begin
            stateNext.awDone = 1'b1;
            stateNext.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !stateReg.wDone) begin
            stateNext.wDone = 1'b1;
            stateNext.wData = s_axi_wdata;
            stateNext.wStrb = s_axi_wstrb;
        end
        if (wrFire) begin
            stateNext.awDone = 1'b0;
            stateNext.wDone  = 1'b0;
            stateNext.bValid = 1'b1;
            stateNext.bResp  = 2'b00;
            if (stateReg.wStrb[0]) begin
                case (stateReg.awAddr)
                    `SWC_OFF_SYSCTRL2: stateNext.sysCtrl2 = stateReg.wData[7:0];
                    `SWC_OFF_TBCTRL:   stateNext.tbCtrl   = stateReg.wData[7:0];
                    `SWC_OFF_IRQCTRL:  stateNext.irqCtrl  = stateReg.wData[1:0];
                    `SWC_OFF_STATUS:   stateNext.bResp    = 2'b10;
                    default:           stateNext.bResp    = 2'b10;
                endcase
            end
            if (stateReg.wStrb[1] && stateReg.awAddr == `SWC_OFF_IRQCTRL) begin
                stateNext.srcEnable = stateReg.wData[8 +: NUM_SRC];
            end
        end
        if (stateReg.bValid && s_axi_bready) begin
            stateNext.bValid = 1'b0;
        end

        // read channel, address taken only while arready stands
        if (s_axi_arvalid && stateReg.arReady) begin
            stateNext.arReady = 1'b0;
            stateNext.rValid  = 1'b1;
            stateNext.rResp   = 2'b00;
            stateNext.rData   = 32'h0000_0000;
            case (s_axi_araddr)
                `SWC_OFF_SYSCTRL2: stateNext.rData[7:0] = stateReg.sysCtrl2;
                `SWC_OFF_TBCTRL:   stateNext.rData[7:0] = stateReg.tbCtrl;
                `SWC_OFF_IRQCTRL: begin
                    stateNext.rData[1:0]          = stateReg.irqCtrl;
                    stateNext.rData[8 +: NUM_SRC] = stateReg.srcEnable;
                end
                `SWC_OFF_STATUS:   stateNext.rData[2:0]  = stateReg.mode;
                `SWC_OFF_PC:       stateNext.rData[15:0] = stateReg.heldPc;
                default:           stateNext.rResp       = 2'b10;
            endcase
        end
        if (stateReg.rValid && s_axi_rready) begin
            stateNext.rValid  = 1'b0;
            stateNext.arReady = 1'b1;
        end

        case (stateReg.mode)
            swc_pkg::SWC_FAST, swc_pkg::SWC_DUALFAST, swc_pkg::SWC_SLOW: begin
                if (stateReg.mode != swc_pkg::SWC_SLOW
                    && stateNext.sysCtrl2[`SWC_BIT_SLOWSEL]) begin
                    stateNext.mode = swc_pkg::SWC_SLOW;
                end
                if (stateReg.mode == swc_pkg::SWC_SLOW
                    && !stateNext.sysCtrl2[`SWC_BIT_SLOWSEL]) begin
                    stateNext.mode    = swc_pkg::SWC_SYNC;
                    stateNext.syncCnt = `SWC_SYNC_CYC;
                end
                if (watchdogIrq) begin
                    stateNext.sysCtrl2[`SWC_BIT_TIMING_GEN_HALT]  = 1'b0;
                    stateNext.sysCtrl2[`SWC_BIT_CPUHALT] = 1'b0;
                end else if (stateNext.sysCtrl2[`SWC_BIT_TIMING_GEN_HALT]) begin
                    stateNext.retMode = stateNext.mode;
                    stateNext.mode    = swc_pkg::SWC_DEEP;
                    stateNext.setTb   = stateNext.tbCtrl[`SWC_BIT_TBEN];
                end else if (stateNext.sysCtrl2[`SWC_BIT_CPUHALT]) begin
                    stateNext.retMode = stateNext.mode;
                    stateNext.mode    = swc_pkg::SWC_HALT;
                end
            end
            swc_pkg::SWC_SYNC: begin
                if (stateReg.syncCnt == 4'h0) begin
                    stateNext.mode = swc_pkg::SWC_DUALFAST;
                end else begin
                    stateNext.syncCnt = stateReg.syncCnt - 4'h1;
                end
            end
            swc_pkg::SWC_HALT: begin
                if (wakeReq) begin
                    stateNext.mode = stateReg.retMode;
                    stateNext.sysCtrl2[`SWC_BIT_CPUHALT] = 1'b0;
                    stateNext.svc   = stateReg.irqCtrl[`SWC_BIT_MASTER];
                    stateNext.noSvc = ~stateReg.irqCtrl[`SWC_BIT_MASTER];
                end
            end
            swc_pkg::SWC_DEEP: begin
                if (tbFall) begin
                    stateNext.mode = stateReg.retMode;
                    stateNext.sysCtrl2[`SWC_BIT_TIMING_GEN_HALT] = 1'b0;
                    stateNext.svc   = andTerm;
                    stateNext.noSvc = ~andTerm;
                end
            end
            default: stateNext.mode = swc_pkg::SWC_FAST;
        endcase

        if (cpuPcValid && stateReg.mode != swc_pkg::SWC_HALT
            && stateReg.mode != swc_pkg::SWC_DEEP) begin
            stateNext.heldPc = cpuPc + `SWC_PC_STEP;
        end

        // ready flags held as registers, high while the slot is empty
        stateNext.awReady = ~stateNext.awDone;
        stateNext.wReady  = ~stateNext.wDone;

        stateNext.outs[9] = stateNext.mode != swc_pkg::SWC_HALT
                          && stateNext.mode != swc_pkg::SWC_DEEP;
        stateNext.outs[8] = stateNext.outs[9];
        stateNext.outs[7] = stateNext.mode != swc_pkg::SWC_DEEP;
        stateNext.outs[6] = 1'b1;
        stateNext.outs[5] = stateNext.mode == swc_pkg::SWC_FAST
                          || stateNext.mode == swc_pkg::SWC_DUALFAST
                          || (stateNext.retMode != swc_pkg::SWC_SLOW
                              && stateNext.retMode != swc_pkg::SWC_SYNC
                              && (stateNext.mode == swc_pkg::SWC_HALT
                                  || stateNext.mode == swc_pkg::SWC_DEEP));
        stateNext.outs[4]   = stateNext.sysCtrl2[`SWC_BIT_HFOSC];
        stateNext.outs[3]   = stateNext.sysCtrl2[`SWC_BIT_LFOSC];
        stateNext.outs[2:0] = stateNext.mode;
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            stateReg          <= '0;
            stateReg.mode     <= swc_pkg::SWC_FAST;
            stateReg.retMode  <= swc_pkg::SWC_FAST;
            stateReg.sysCtrl2 <= `SWC_RST_SYSCTRL2;
            stateReg.tbCtrl   <= `SWC_RST_TBCTRL;
            stateReg.awReady  <= 1'b1;
            stateReg.wReady   <= 1'b1;
            stateReg.arReady  <= 1'b1;
            stateReg.outs     <= 10'b11_1111_0000;
        end else begin
            stateReg <= stateNext;
        end
    end

    assign cpuClkRun       = stateReg.outs[9];
    assign wdtClkRun       = stateReg.outs[8];
    assign periphClkRun    = stateReg.outs[7];
    assign tbClkRun        = stateReg.outs[6];
    assign useFastClk      = stateReg.outs[5];
    assign hfOscOn         = stateReg.outs[4];
    assign lfOscOn         = stateReg.outs[3];
    assign modeOut         = stateReg.outs[2:0];
    assign setTbPending    = stateReg.setTb;
    assign serviceStart    = stateReg.svc;
    assign resumeNoService = stateReg.noSvc;
    assign s_axi_awready   = stateReg.awReady;
    assign s_axi_wready    = stateReg.wReady;
    assign s_axi_bvalid    = stateReg.bValid;
    assign s_axi_bresp     = stateReg.bResp;
    assign s_axi_arready   = stateReg.arReady;
    assign s_axi_rvalid    = stateReg.rValid;
    assign s_axi_rdata     = stateReg.rData;
    assign s_axi_rresp     = stateReg.rResp;
endmodule

// File: tb/swc_standby_props.sv
module swc_standby_props (
    // clock and reset
    input wire logic       clk,
    input wire logic       sys_rst,
    // wake and entry events
    input wire logic       serviceStart,
    input wire logic       resumeNoService,
    input wire logic       setTbPending,
    input wire logic       watchdogIrq,
    // clock gating and mode
    input wire logic       cpuClkRun,
    input wire logic       wdtClkRun,
    input wire logic       periphClkRun,
    input wire logic       tbClkRun,
    input wire logic       useFastClk,
    input wire logic [2:0] modeOut
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic hlt;
    assign hlt = modeOut == 3'h4 || modeOut == 3'h5;

    a_deep_gates: assert property (
        modeOut == 3'h5 |-> !cpuClkRun && !periphClkRun && tbClkRun)
        else $error("deep halt clock gating wrong");
    a_halt_gates: assert property (
        modeOut == 3'h4 |-> !cpuClkRun && !wdtClkRun && periphClkRun && tbClkRun)
        else $error("cpu halt clock gating wrong");
    a_wake_pulse: assert property (
        $past(hlt) && !hlt |-> ##[0:2] (serviceStart || resumeNoService))
        else $error("wake without wake pulse");
    a_pulse_source: assert property (
        serviceStart || resumeNoService |-> !hlt && ($past(hlt) || $past(hlt, 2)))
        else $error("wake pulse without a halt");
    a_tb_latch: assert property (
        setTbPending |-> ##[0:1] modeOut == 3'h5)
        else $error("timebase latch set outside deep entry");
    a_wdog_skip: assert property (
        watchdogIrq && !hlt |=> !hlt)
        else $error("halt entered with watchdog interrupt");
    a_slow_clock: assert property (
        modeOut == 3'h2 || modeOut == 3'h3 |-> !useFastClk)
        else $error("fast clock used before sync");
    a_sync_ends: assert property (
        $rose(modeOut == 3'h3) |-> ##[1:8] modeOut == 3'h1)
        else $error("sync never reached dual fast");
    a_reset_fast: assert property (
        $past(sys_rst) |-> modeOut == 3'h0 && useFastClk && cpuClkRun)
        else $error("reset did not restart in fast mode");
endmodule

bind swc_standby_ctrl swc_standby_props u_props (.clk(clk), .sys_rst(sys_rst),
    .serviceStart(serviceStart), .resumeNoService(resumeNoService),
    .setTbPending(setTbPending), .watchdogIrq(watchdogIrq), .cpuClkRun(cpuClkRun),
    .wdtClkRun(wdtClkRun), .periphClkRun(periphClkRun), .tbClkRun(tbClkRun),
    .useFastClk(useFastClk), .modeOut(modeOut));

// File: tb/swc_cpu_model.sv
module swc_cpu_model #(
    parameter int NUM_SRC = 8,
    parameter int TB_SRC  = 6
) (
    // clock and reset
    input wire logic               clk,
    input wire logic               sys_rst,
    // bench side
    input wire logic [NUM_SRC-1:0] irqRaise,
    input wire logic [NUM_SRC-1:0] irqClear,
    input wire logic [15:0]        pcHold,
    // controller side
    input wire logic               setTbPending,
    input wire logic               serviceStart,
    input wire logic               resumeNoService,
    input wire logic               cpuClkRun,
    output logic [NUM_SRC-1:0]     irqPending,
    output logic                   cpuPcValid,
    output logic [15:0]            cpuPc,
    // event counts
    output int                     svcCnt,
    output int                     resCnt,
    output int                     tbCnt
);
    timeunit 1ns;
    timeprecision 1ps;
    assign cpuPc = pcHold;
    assign cpuPcValid = cpuClkRun;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            irqPending <= '0;
            svcCnt <= 0;
            resCnt <= 0;
            tbCnt <= 0;
        end else begin
            irqPending <= (irqPending | irqRaise | (NUM_SRC'(setTbPending) << TB_SRC))
                & ~irqClear & ~{NUM_SRC{serviceStart}};
            svcCnt <= svcCnt + int'(serviceStart);
            resCnt <= resCnt + int'(resumeNoService);
            tbCnt <= tbCnt + int'(setTbPending);
        end
    end
endmodule

// File: tb/test_standby_wake_and_clock_switch.sv
`include "swc_consts.svh"
module test_standby_wake_and_clock_switch;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int NS = 8;
    logic          clk, sys_rst, awv, awr, wv, wr, bv, br, arv, arr, rv, rr, wdog;
    logic          pcv, tbSet, svc, res, cpuRun, wdtRun, perRun, tbRun, fast, hfOn, lfOn;
    logic [7:0]    awa, ara, tbClk;
    logic [31:0]   wd, rd, got;
    logic [1:0]    bresp, rresp, gr;
    logic [2:0]    mode;
    logic [15:0]   pc, pcHold;
    logic [NS-1:0] pend, raise, clr;
    int            svcCnt, resCnt, tbCnt, mismatches, samples_checked, cyc, eSvc, eRes, eTb;
    int            k, sel;

    swc_standby_ctrl #(.NUM_SRC(NS), .TB_SRC(6)) dut (.clk(clk), .sys_rst(sys_rst),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_wvalid(wv),
        .s_axi_wready(wr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_bvalid(bv),
        .s_axi_bready(br), .s_axi_bresp(bresp), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rr), .s_axi_rdata(rd),
        .s_axi_rresp(rresp), .irqPending(pend), .watchdogIrq(wdog), .cpuPcValid(pcv),
        .cpuPc(pc), .setTbPending(tbSet), .serviceStart(svc), .resumeNoService(res),
        .tbSrcClocks(tbClk), .cpuClkRun(cpuRun), .wdtClkRun(wdtRun), .periphClkRun(perRun),
        .tbClkRun(tbRun), .useFastClk(fast), .hfOscOn(hfOn), .lfOscOn(lfOn), .modeOut(mode));
    swc_cpu_model #(.NUM_SRC(NS), .TB_SRC(6)) cpu (.clk(clk), .sys_rst(sys_rst),
        .irqRaise(raise), .irqClear(clr), .pcHold(pcHold), .setTbPending(tbSet),
        .serviceStart(svc), .resumeNoService(res), .cpuClkRun(cpuRun), .irqPending(pend),
        .cpuPcValid(pcv), .cpuPc(pc), .svcCnt(svcCnt), .resCnt(resCnt), .tbCnt(tbCnt));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            mismatches++;
            results();
        end
    end

    task automatic chk(input logic [31:0] e, input logic [31:0] a);
        samples_checked++;
        if (a !== e) begin
            mismatches++;
            $display("mismatch at %0t exp %h got %h", $time, e, a);
        end
    endtask

    task automatic wrReg(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ta, tw;
        @(posedge clk);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        ta = 1'b0;
        tw = 1'b0;
        while (!(ta && tw)) begin
            @(negedge clk);
            ta = ta || (awv && awr);
            tw = tw || (wv && wr);
            @(posedge clk);
            if (ta) awv <= 1'b0;
            if (tw) wv <= 1'b0;
        end
        do @(negedge clk); while (bv !== 1'b1);
        chk(32'(er), 32'(bresp));
        @(posedge clk);
        br <= 1'b0;
    endtask

    task automatic rdChk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        logic ta, tv;
        @(posedge clk);
        ara <= a;
        arv <= 1'b1;
        rr <= 1'b1;
        tv = 1'b0;
        while (!tv) begin
            @(negedge clk);
            ta = arv && arr;
            tv = rv;
            got = rd;
            gr = rresp;
            @(posedge clk);
            if (ta) arv <= 1'b0;
        end
        rr <= 1'b0;
        chk(32'(er), 32'(gr));
        chk(e, got);
    endtask

    task automatic waitNot(input logic [2:0] a, input logic [2:0] b);
        int n;
        n = 0;
        while ((mode === a || mode === b) && n < 64) begin
            @(negedge clk);
            n++;
        end
        repeat (3) @(posedge clk);
    endtask

    initial begin
        {awv, wv, br, arv, rr, wdog} = '0;
        {awa, ara, wd, raise, clr, pcHold} = '0;
        tbClk = 8'hFF;
        {mismatches, samples_checked, cyc, eSvc, eRes, eTb} = '0;
        sys_rst = 1'b1;
        void'($urandom(32'h48b4_e1c6));
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        rdChk(`SWC_OFF_SYSCTRL2, 32'h80, 2'h0);
        rdChk(`SWC_OFF_STATUS, 32'h0, 2'h0);
        rdChk(8'h20, 32'h0, 2'h2);
        wrReg(`SWC_OFF_STATUS, 32'h1, 2'h2);
        $display("test reset done");
        for (int m = 0; m < 2; m++) begin
            k = $urandom % NS;
            wrReg(`SWC_OFF_IRQCTRL, 32'(m) | (32'h1 << (8 + k)), 2'h0);
            wrReg(`SWC_OFF_SYSCTRL2, 32'h84, 2'h0);
            raise[(k + 1) % NS] <= 1'b1;
            @(posedge clk);
            raise <= '0;
            rdChk(`SWC_OFF_STATUS, 32'h4, 2'h0);
            raise[k] <= 1'b1;
            @(posedge clk);
            raise <= '0;
            waitNot(3'h4, 3'h5);
            if (m == 1) eSvc++;
            else eRes++;
            chk(eSvc, svcCnt);
            chk(eRes, resCnt);
            rdChk(`SWC_OFF_SYSCTRL2, 32'h80, 2'h0);
            rdChk(`SWC_OFF_STATUS, 32'h0, 2'h0);
            clr <= '1;
            @(posedge clk);
            clr <= '0;
        end
        $display("test cpu halt done");
        wdog <= 1'b1;
        wrReg(`SWC_OFF_SYSCTRL2, 32'h84, 2'h0);
        wrReg(`SWC_OFF_SYSCTRL2, 32'h90, 2'h0);
        wdog <= 1'b0;
        rdChk(`SWC_OFF_STATUS, 32'h0, 2'h0);
        rdChk(`SWC_OFF_SYSCTRL2, 32'h80, 2'h0);
        $display("test watchdog done");
        for (int c = 0; c < 3; c++) begin
            sel = $urandom % 8;
            pcHold <= 16'($urandom);
            wrReg(`SWC_OFF_TBCTRL, 32'(sel) | (c > 0 ? 32'h8 : 32'h0), 2'h0);
            wrReg(`SWC_OFF_IRQCTRL, (c != 1) ? 32'h3 : 32'h0, 2'h0);
            wrReg(`SWC_OFF_SYSCTRL2, 32'h90, 2'h0);
            if (c > 0) eTb++;
            @(negedge clk);
            chk(eTb, tbCnt);
            rdChk(`SWC_OFF_STATUS, 32'h5, 2'h0);
            rdChk(`SWC_OFF_PC, 32'(16'(pcHold + 16'h0002)), 2'h0);
            tbClk[sel] <= 1'b0;
            waitNot(3'h4, 3'h5);
            tbClk[sel] <= 1'b1;
            if (c == 2) eSvc++;
            else eRes++;
            chk(eSvc, svcCnt);
            chk(eRes, resCnt);
            rdChk(`SWC_OFF_SYSCTRL2, 32'h80, 2'h0);
            clr <= '1;
            @(posedge clk);
            clr <= '0;
        end
        $display("test deep halt done");
        wrReg(`SWC_OFF_SYSCTRL2, 32'hE0, 2'h0);
        rdChk(`SWC_OFF_STATUS, 32'h2, 2'h0);
        wrReg(`SWC_OFF_SYSCTRL2, 32'h60, 2'h0);
        chk(32'h0, 32'(hfOn));
        chk(32'h1, 32'(lfOn));
        wrReg(`SWC_OFF_SYSCTRL2, 32'h70, 2'h0);
        tbClk[sel] <= 1'b0;
        waitNot(3'h4, 3'h5);
        tbClk[sel] <= 1'b1;
        rdChk(`SWC_OFF_STATUS, 32'h2, 2'h0);
        wrReg(`SWC_OFF_SYSCTRL2, 32'hE0, 2'h0);
        repeat (20) @(posedge clk);
        wrReg(`SWC_OFF_SYSCTRL2, 32'hC0, 2'h0);
        waitNot(3'h3, 3'h3);
        rdChk(`SWC_OFF_STATUS, 32'h1, 2'h0);
        chk(32'h1, 32'(fast));
        wrReg(`SWC_OFF_SYSCTRL2, 32'hE0, 2'h0);
        sys_rst <= 1'b1;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        rdChk(`SWC_OFF_STATUS, 32'h0, 2'h0);
        rdChk(`SWC_OFF_SYSCTRL2, 32'h80, 2'h0);
        $display("test slow switch done");
        results();
    end
endmodule
